// ---- logic/wdm_window_watchdog_monitor.v ----
// Window watchdog monitor with register port and interrupt
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "wdm_defines.vh"
module wdm_window_watchdog_monitor #(
  parameter [23:0] HOLD_CYC = `WDM_HOLD_US * (`WDM_CLK_HZ / 1000000),
  parameter [23:0] START_CYC = `WDM_START_US * (`WDM_CLK_HZ / 1000000),
  parameter [23:0] SLOW_CYC_DEF = `WDM_SLOW_US_DEF * (`WDM_CLK_HZ / 1000000)
) (
  input wire clock,
  input wire srst,
  input wire kickClockIn,
  input wire watchdogEnableLow,
  input wire mainRailGood,
  input wire auxRailGood,
  input wire [3:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata,
  output reg resetOutN,
  output reg resetOutOe,
  output reg faultFlag,
  output reg irq
);
  // ****************************************
  // States
  // ****************************************
  localparam [3:0] ST_OFF = 4'h1;
  localparam [3:0] ST_WAIT = 4'h2;
  localparam [3:0] ST_RUN = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [2:0] kickSync_reg;
  reg [2:0] enSync_reg;
  reg [2:0] mainSync_reg;
  reg [2:0] auxSync_reg;
  reg kickLvl_reg;
  reg enLowLvl_reg;
  reg mainLvl_reg;
  reg auxLvl_reg;
  always @(posedge clock) begin
    if (srst) begin
      kickSync_reg <= 3'h0;
      enSync_reg <= 3'h7;
      mainSync_reg <= 3'h0;
      auxSync_reg <= 3'h0;
      kickLvl_reg <= 1'b0;
      enLowLvl_reg <= 1'b1;
      mainLvl_reg <= 1'b0;
      auxLvl_reg <= 1'b0;
    end else begin
      kickSync_reg <= {kickSync_reg[1:0], kickClockIn};
      enSync_reg <= {enSync_reg[1:0], watchdogEnableLow};
      mainSync_reg <= {mainSync_reg[1:0], mainRailGood};
      auxSync_reg <= {auxSync_reg[1:0], auxRailGood};
      // Level changes only once the last two stages agree
      if (kickSync_reg[2] == kickSync_reg[1]) kickLvl_reg <= kickSync_reg[2];
      if (enSync_reg[2] == enSync_reg[1]) enLowLvl_reg <= enSync_reg[2];
      if (mainSync_reg[2] == mainSync_reg[1]) mainLvl_reg <= mainSync_reg[2];
      if (auxSync_reg[2] == auxSync_reg[1]) auxLvl_reg <= auxSync_reg[2];
    end
  end

  reg kickPrev_reg;
  always @(posedge clock) begin
    if (srst) kickPrev_reg <= 1'b0;
    else kickPrev_reg <= kickLvl_reg;
  end
  wire kickRise = kickLvl_reg & ~kickPrev_reg;
  wire active = ~enLowLvl_reg & mainLvl_reg & auxLvl_reg;

  // ****************************************
  // Registers
  // ****************************************
  reg [`WDM_CNT_W-1:0] slowCyc_reg;
  reg [`WDM_EV_W-1:0] status_reg;
  reg [`WDM_EV_W-1:0] mask_reg;
  reg forceOff_reg;
  wire [`WDM_CNT_W-1:0] fastCyc = slowCyc_reg >> `WDM_FAST_DIV_SHIFT;

  function hitAddr;
    input [3:0] addr;
    input [3:0] target;
    begin
      hitAddr = (addr == target);
    end
  endfunction

  // ****************************************
  // Watchdog engine
  // ****************************************
  reg [3:0] state_reg;
  reg [`WDM_CNT_W-1:0] cnt_reg;
  reg [`WDM_CNT_W-1:0] holdCnt_reg;
  reg seenEdge_reg;
  reg armed_reg;
  reg [`WDM_EV_W-1:0] event_reg;
  always @(posedge clock) begin
    if (srst) begin
      state_reg <= ST_OFF;
      cnt_reg <= {`WDM_CNT_W{1'b0}};
      holdCnt_reg <= {`WDM_CNT_W{1'b0}};
      seenEdge_reg <= 1'b0;
      armed_reg <= 1'b0;
      event_reg <= {`WDM_EV_W{1'b0}};
    end else begin
      event_reg <= {`WDM_EV_W{1'b0}};
      if (!active || forceOff_reg) begin
        // Any drop of enable or rails restarts the activation delay
        state_reg <= ST_OFF;
        cnt_reg <= {`WDM_CNT_W{1'b0}};
        seenEdge_reg <= 1'b0;
        armed_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_OFF: begin
            state_reg <= ST_WAIT;
            cnt_reg <= {`WDM_CNT_W{1'b0}};
          end
          ST_WAIT: begin
            // Startup grace spans activation delay plus slow timeout
            // Kicks before the activation delay are ignored, not measured
            if (kickRise && cnt_reg >= START_CYC) begin
              state_reg <= ST_RUN;
              cnt_reg <= {`WDM_CNT_W{1'b0}};
              seenEdge_reg <= 1'b1;
              armed_reg <= 1'b1;
            end else if (cnt_reg >= START_CYC + slowCyc_reg - 1'b1) begin
              state_reg <= ST_HOLD;
              holdCnt_reg <= {`WDM_CNT_W{1'b0}};
              event_reg[`WDM_EV_MISS] <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
          ST_RUN: begin
            if (kickRise) begin
              if (armed_reg && cnt_reg < fastCyc) begin
                state_reg <= ST_HOLD;
                holdCnt_reg <= {`WDM_CNT_W{1'b0}};
                event_reg[`WDM_EV_FAST] <= 1'b1;
              end
              cnt_reg <= {`WDM_CNT_W{1'b0}};
              armed_reg <= 1'b1;
            end else if (armed_reg && cnt_reg >= slowCyc_reg) begin
              state_reg <= ST_HOLD;
              holdCnt_reg <= {`WDM_CNT_W{1'b0}};
              event_reg[`WDM_EV_SLOW] <= 1'b1;
            end else if (!armed_reg && cnt_reg >= slowCyc_reg) begin
              // No edge since the last hold: missing clock, repeat
              state_reg <= ST_HOLD;
              holdCnt_reg <= {`WDM_CNT_W{1'b0}};
              event_reg[`WDM_EV_MISS] <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
          ST_HOLD: begin
            if (holdCnt_reg >= HOLD_CYC - 1'b1) begin
              state_reg <= ST_RUN;
              cnt_reg <= {`WDM_CNT_W{1'b0}};
              armed_reg <= 1'b0;
            end else begin
              holdCnt_reg <= holdCnt_reg + 1'b1;
            end
          end
          default: begin
            state_reg <= ST_OFF;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Register port and interrupt
  // ****************************************
  always @(posedge clock) begin
    if (srst) begin
      slowCyc_reg <= SLOW_CYC_DEF;
      mask_reg <= {`WDM_EV_W{1'b0}};
      status_reg <= {`WDM_EV_W{1'b0}};
      forceOff_reg <= 1'b0;
      regRdata <= 32'h0;
    end else begin
      regRdata <= 32'h0;
      if (regWrite && hitAddr(regAddr, `WDM_REG_CTRL)) forceOff_reg <= regWdata[0];
      if (regWrite && hitAddr(regAddr, `WDM_REG_MASK)) mask_reg <= regWdata[`WDM_EV_W-1:0];
      if (regWrite && hitAddr(regAddr, `WDM_REG_SLOW)) slowCyc_reg <= regWdata[`WDM_CNT_W-1:0];
      // Set beats clear so an event in the clearing cycle survives
      if (regWrite && hitAddr(regAddr, `WDM_REG_STAT))
        status_reg <= (status_reg & ~regWdata[`WDM_EV_W-1:0]) | event_reg;
      else
        status_reg <= status_reg | event_reg;
      if (regRead) begin
        if (hitAddr(regAddr, `WDM_REG_CTRL))
          regRdata <= {27'h0, state_reg, forceOff_reg};
        else if (hitAddr(regAddr, `WDM_REG_STAT))
          regRdata <= {29'h0, status_reg};
        else if (hitAddr(regAddr, `WDM_REG_MASK))
          regRdata <= {29'h0, mask_reg};
        else if (hitAddr(regAddr, `WDM_REG_SLOW))
          regRdata <= {8'h0, slowCyc_reg};
      end
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      resetOutN <= 1'b1;
      resetOutOe <= 1'b0;
      faultFlag <= 1'b0;
      irq <= 1'b0;
    end else begin
      // Open drain: drive low only during the hold
      resetOutN <= 1'b0;
      resetOutOe <= (state_reg == ST_HOLD) && active && !forceOff_reg;
      faultFlag <= (state_reg == ST_HOLD) && active && !forceOff_reg;
      irq <= |(((status_reg | event_reg)) & mask_reg);
    end
  end
endmodule

// ---- logic/wdm_defines.vh ----
// Constants for the window watchdog monitor
// Operation
// - Measure interval between kick rising edges
// - Fault pulls reset low for hold time
// - Too short is fast fault, too long slow
// - Fast limit equals slow timeout over eight
// - Slow timeout programmable, SLOW register sets it
// - Active only while enable low pin low
// - Start after rails good for activation delay
// - No edge in delay plus timeout faults
// - Missing-clock fault repeats until edges resume
`ifndef WDM_DEFINES_VH
`define WDM_DEFINES_VH
// ****************************************
// Timing
// ****************************************
`define WDM_CLK_HZ 10000000
`define WDM_HOLD_US 2000
`define WDM_START_US 30000
`define WDM_SLOW_US_DEF 10000
`define WDM_FAST_DIV_SHIFT 3
`define WDM_CNT_W 24
// ****************************************
// Register map
// ****************************************
`define WDM_ADDR_W 4
`define WDM_REG_CTRL 4'h0
`define WDM_REG_STAT 4'h4
`define WDM_REG_MASK 4'h8
`define WDM_REG_SLOW 4'hc
`define WDM_EV_FAST 0
`define WDM_EV_SLOW 1
`define WDM_EV_MISS 2
`define WDM_EV_W 3
`endif

// ---- test/wdm_kick_model.sv ----
// Kick clock source standing in for the host processor
`timescale 1ns/100ps
module wdm_kick_model (
  input wire logic clock,
  input wire logic run,
  input wire logic [15:0] period,
  output logic kick
);
  logic [15:0] count_reg = 16'h0;
  initial kick = 1'b0;
  // Pin rests low between kicks; the host pulls it high for two cycles
  always @(posedge clock) begin
    if (!run || count_reg == period - 16'h1) begin
      count_reg <= 16'h0;
    end else begin
      count_reg <= count_reg + 16'h1;
    end
    kick <= run && count_reg < 16'h2;
  end
endmodule

// ---- test/wdm_monitor_props.sv ----
// Port checks for the window watchdog monitor
`timescale 1ns/100ps
module wdm_monitor_props #(
  parameter [23:0] HOLD_CYC = 24'h4e20,
  parameter [23:0] START_CYC = 24'h0493e0,
  parameter [23:0] SLOW_CYC_DEF = 24'h0186a0
) (
  input wire clock,
  input wire srst,
  input wire kickClockIn,
  input wire watchdogEnableLow,
  input wire mainRailGood,
  input wire auxRailGood,
  input wire regRead,
  input wire [31:0] regRdata,
  input wire resetOutN,
  input wire resetOutOe,
  input wire faultFlag
);
  // Margin covers the pin synchronizer and output register
  localparam int IDLE_MAX = START_CYC + SLOW_CYC_DEF + 16;
  logic [23:0] holdCnt = 24'h0, upCnt = 24'h0, idleCnt = 24'h0;
  logic kickQ = 1'b0;
  wire live = !watchdogEnableLow && mainRailGood && auxRailGood;
  always @(posedge clock) begin
    kickQ <= kickClockIn;
    holdCnt <= (srst || !resetOutOe) ? 24'h0 : holdCnt + 24'h1;
    upCnt <= (srst || !live) ? 24'h0 : upCnt + {23'h0, upCnt != 24'hffffff};
    idleCnt <= (srst || !live || resetOutOe || (kickClockIn && !kickQ)) ? 24'h0 : idleCnt + 24'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence quietRun;
    !resetOutOe [*8];
  endsequence
  a_hold_len: assert property ($fell(resetOutOe) |-> holdCnt == HOLD_CYC)
    else $error("hold length wrong");
  a_pin_level: assert property (resetOutOe |-> !resetOutN && faultFlag)
    else $error("pin or flag wrong in hold");
  a_flag_oe: assert property (faultFlag == resetOutOe)
    else $error("flag out of step");
  a_off_quiet: assert property (!live [*4] |-> !$rose(resetOutOe))
    else $error("fault while off");
  a_no_early: assert property ($rose(resetOutOe) |-> upCnt >= START_CYC)
    else $error("fault before activation");
  a_idle_bound: assert property (idleCnt <= IDLE_MAX)
    else $error("missing kick not faulted");
  a_release_quiet: assert property ($fell(resetOutOe) |-> quietRun)
    else $error("fault right after release");
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside slot");
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the window watchdog monitor
`timescale 1ns/100ps
module testbench;
  // ****
  // Set-up
  // ****
  localparam int HC = 20, SC = 300, LC = 160;
  logic clock = 0, srst = 1, enLow = 1, rails = 1, run = 0, wr = 0, rd = 0, oeQ = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] period = 16'h50;
  logic kick, rstN, oe, flag, irq;
  int fails = 0, n_tests = 0, cyc = 0, nRise = 0, i;
  int rows [4][2] = '{'{80, 0}, '{22, 0}, '{18, 1}, '{200, 1}};
  initial forever #50 clock = ~clock;
  wdm_kick_model u_host (.clock(clock), .run(run), .period(period), .kick(kick));
  wdm_window_watchdog_monitor #(.HOLD_CYC(HC), .START_CYC(SC), .SLOW_CYC_DEF(LC)) u_dut (
    .clock(clock), .srst(srst), .kickClockIn(kick), .watchdogEnableLow(enLow),
    .mainRailGood(rails), .auxRailGood(rails), .regAddr(addr), .regWdata(wdata),
    .regWrite(wr), .regRead(rd), .regRdata(rdata), .resetOutN(rstN),
    .resetOutOe(oe), .faultFlag(flag), .irq(irq));
  // Counted on the falling edge, away from the sampling edge, so the pin has settled
  always @(negedge clock) begin
    oeQ <= oe;
    if (oe && !oeQ) nRise++;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 12000) begin
      fails++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr <= 1; tick(1); wr <= 0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
    addr <= a; rd <= 1; tick(1); rd <= 0; #1;
    check(rdata, exp);
  endtask
  task automatic restart();
    srst <= 1; run <= 0; enLow <= 1; tick(5); srst <= 0; enLow <= 0; nRise = 0;
  endtask
  task automatic conclude();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    for (i = 0; i < 4; i++) begin
      restart();
      period <= rows[i][0];
      tick(SC + 10); run <= 1; tick(700); run <= 0; #1;
      check(nRise != 0, rows[i][1]);
    end
    restart();
    period <= 16'ha; run <= 1; tick(SC - 20); run <= 0; #1;
    check(nRise, 0);
    restart();
    rreg(4'hc, LC);
    rreg(4'h2, 0);
    wreg(4'h8, 32'h7);
    tick(SC + LC + 30); #1;
    check(nRise, 1);
    check(irq, 1);
    rreg(4'h4, 32'h4);
    tick(200); #1;
    check(nRise, 2);
    enLow <= 1; tick(30); wreg(4'h4, 32'h7); tick(2); #1;
    check(irq, 0);
    tick(300); enLow <= 0; rails <= 0; tick(600); #1;
    check(nRise, 2);
    conclude();
  end
endmodule
bind wdm_window_watchdog_monitor wdm_monitor_props #(.HOLD_CYC(HOLD_CYC),
  .START_CYC(START_CYC), .SLOW_CYC_DEF(SLOW_CYC_DEF)) u_props (.clock(clock),
  .srst(srst), .kickClockIn(kickClockIn), .watchdogEnableLow(watchdogEnableLow),
  .mainRailGood(mainRailGood), .auxRailGood(auxRailGood), .regRead(regRead),
  .regRdata(regRdata), .resetOutN(resetOutN), .resetOutOe(resetOutOe), .faultFlag(faultFlag));
